// ---- hw/t1fm_defs.svh ----
// Offsets, field positions, reset values and widths of the F-bit monitor.
// Included by the monitor; holds definitions only.
`ifndef T1FM_DEFS_SVH
`define T1FM_DEFS_SVH

`define T1FM_CNT_W 12
`define T1FM_CNT_MAX 12'hfff
`define T1FM_CNT_RST 12'h000

`define T1FM_OFF_CNT_HIGH 8'h25
`define T1FM_OFF_PATH_LOW 8'h26
`define T1FM_OFF_SYNC_LOW 8'h27
`define T1FM_OFF_LINK_BYTE 8'h28
`define T1FM_OFF_MATCH_A 8'h29
`define T1FM_OFF_MATCH_B 8'h2a
`define T1FM_OFF_FRAME_CTRL 8'h30
`define T1FM_OFF_RECV_CTRL 8'h31
`define T1FM_OFF_STATUS 8'h32
`define T1FM_OFF_MASK 8'h33

`define T1FM_BIT_FRAMING_MODE 3
`define T1FM_BIT_ZERO_DESTUFF 0
`define T1FM_BIT_FS_ERR_EN 1
`define T1FM_BIT_SYNC_SELECT 0
`define T1FM_BIT_ONE_SECOND 5
`define T1FM_BIT_BYTE_FULL 4
`define T1FM_BIT_MATCH 2
`define T1FM_BIT_ABORT 1

`define T1FM_BYTE_RST 8'h00
`define T1FM_BITS_PER_BYTE 3'h7
`define T1FM_STUFF_RUN 4'h5
`define T1FM_ABORT_RUN 4'h8

`endif

// ---- hw/t1fm_pkg.sv ----
// Types shared by the F-bit monitor.
// No dependencies.
package t1fm_pkg;

   typedef enum logic [1:0] {
      T1FM_D4 = 2'b01,
      T1FM_ESF = 2'b10
   } t1fm_frame_mode_t;

endpackage : t1fm_pkg

// ---- hw/t1fm_rx_fbit_monitor.sv ----
// Receive F-bit monitor: path and sync-loss counters, link byte extraction.
// Assumes all event inputs come from framer logic on core_clk_in, as pulses.
//
// Contract
// (R1) Path error count is twelve bits
// (R2) Extended superframe: path counter counts CRC6 errors
// (R3) D4: count Ft errors, plus Fs if enabled
// (R4) Shared high byte: path low, sync high
// (R5) Sync-loss counter twelve bits, low byte separate
// (R6) Select one: count out-of-sync multiframes always
// (R7) Select zero: count Ft or FPS errors
// (R8) Framing-error mode halts during sync loss
// (R9) Link or Fs bits shift into byte
// (R10) First received bit lands in LSB
// (R11) Byte completes after eight link bits
// (R12) Full byte sets flag, masked interrupt low
// (R13) Host reads byte before next fills
// (R14) Byte matching either pattern sets match flag
// (R15) Destuff zero after exactly five ones
// (R16) Zero after six or more ones kept
// (R17) Host enables destuffing when extracting link
// (R18) Counters load on one-second boundaries
// (R19) Counters saturate, never wrap
// (R20) Path counter halts during sync loss
// (R21) Eight consecutive ones set abort flag
// (R22) Discarded zeros do not enter byte
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "t1fm_defs.svh"

module t1fm_rx_fbit_monitor (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic ft_error_in,
   input wire logic fs_error_in,
   input wire logic fps_error_in,
   input wire logic crc6_error_in,
   input wire logic multiframe_in,
   input wire logic receive_sync_lost_in,
   input wire logic one_second_in,
   input wire logic link_bit_valid_in,
   input wire logic link_bit_in,
   output logic second_interrupt_n_out
);

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   logic framing_mode_select_q;
   logic zero_destuff_enable_q;
   logic fs_error_count_enable_q;
   logic sync_loss_count_select_q;
   logic [7:0] link_match_byte_a_q;
   logic [7:0] link_match_byte_b_q;
   logic link_byte_full_mask_q;
   logic link_match_mask_q;
   t1fm_pkg::t1fm_frame_mode_t mode;

   assign mode = framing_mode_select_q ? t1fm_pkg::T1FM_ESF : t1fm_pkg::T1FM_D4;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         framing_mode_select_q <= 1'b0;
         zero_destuff_enable_q <= 1'b0;
         fs_error_count_enable_q <= 1'b0;
         sync_loss_count_select_q <= 1'b0;
         link_match_byte_a_q <= `T1FM_BYTE_RST;
         link_match_byte_b_q <= `T1FM_BYTE_RST;
         link_byte_full_mask_q <= 1'b0;
         link_match_mask_q <= 1'b0;
      end else if (wr_in) begin
         case (addr_in)
            `T1FM_OFF_FRAME_CTRL: begin
               framing_mode_select_q <= wdata_in[`T1FM_BIT_FRAMING_MODE];
               zero_destuff_enable_q <= wdata_in[`T1FM_BIT_ZERO_DESTUFF];
            end
            `T1FM_OFF_RECV_CTRL: begin
               fs_error_count_enable_q <= wdata_in[`T1FM_BIT_FS_ERR_EN];
               sync_loss_count_select_q <= wdata_in[`T1FM_BIT_SYNC_SELECT];
            end
            `T1FM_OFF_MATCH_A: link_match_byte_a_q <= wdata_in;
            `T1FM_OFF_MATCH_B: link_match_byte_b_q <= wdata_in;
            `T1FM_OFF_MASK: begin
               link_byte_full_mask_q <= wdata_in[`T1FM_BIT_BYTE_FULL];
               link_match_mask_q <= wdata_in[`T1FM_BIT_MATCH];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Performance counters: live count runs, snapshot taken each second
   logic path_event;
   logic sync_event;
   logic [11:0] path_live_q;
   logic [11:0] sync_live_q;
   logic [11:0] path_error_count_q;
   logic [11:0] sync_loss_count_q;

   always_comb begin
      if (mode == t1fm_pkg::T1FM_ESF) begin
         path_event = crc6_error_in; // R2
      end else begin
         path_event = ft_error_in | (fs_error_count_enable_q & fs_error_in); // R3
      end
      path_event = path_event & ~receive_sync_lost_in; // R20
      if (sync_loss_count_select_q) begin
         sync_event = multiframe_in & receive_sync_lost_in; // R6
      end else begin
         // Framing-error mode is blind while out of sync
         sync_event = ((mode == t1fm_pkg::T1FM_ESF) ? fps_error_in : ft_error_in)
                      & ~receive_sync_lost_in; // R7 R8
      end
   end

   // An event in the snapshot cycle starts the new second, so none is lost
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         path_live_q <= `T1FM_CNT_RST;
      end else if (one_second_in) begin
         path_live_q <= {11'h000, path_event}; // R18
      end else if (path_event && path_live_q != `T1FM_CNT_MAX) begin
         path_live_q <= path_live_q + 12'h001; // R1 R19
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync_live_q <= `T1FM_CNT_RST;
      end else if (one_second_in) begin
         sync_live_q <= {11'h000, sync_event}; // R18
      end else if (sync_event && sync_live_q != `T1FM_CNT_MAX) begin
         sync_live_q <= sync_live_q + 12'h001; // R5 R19
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         path_error_count_q <= `T1FM_CNT_RST;
         sync_loss_count_q <= `T1FM_CNT_RST;
      end else if (one_second_in) begin
         path_error_count_q <= path_live_q; // R18
         sync_loss_count_q <= sync_live_q; // R18
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link extraction with zero destuffing
   logic [3:0] ones_run_q;
   logic [7:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] receive_link_byte_q;
   logic drop_zero;
   logic byte_done;
   logic [7:0] new_byte;

   // A run of exactly five ones marks a stuffed zero; six or more do not
   assign drop_zero = zero_destuff_enable_q & ~link_bit_in
                      & (ones_run_q == `T1FM_STUFF_RUN); // R15 R16
   assign byte_done = link_bit_valid_in & ~drop_zero
                      & (bit_cnt_q == `T1FM_BITS_PER_BYTE); // R11 R22
   assign new_byte = {link_bit_in, shift_q[7:1]}; // R10

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ones_run_q <= 4'h0;
      end else if (link_bit_valid_in) begin
         if (!link_bit_in) begin
            ones_run_q <= 4'h0;
         end else if (ones_run_q != `T1FM_ABORT_RUN) begin
            ones_run_q <= ones_run_q + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         shift_q <= `T1FM_BYTE_RST;
         bit_cnt_q <= 3'h0;
      end else if (link_bit_valid_in && !drop_zero) begin
         shift_q <= new_byte; // R9 R22
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   // Overwritten if the host is slow; no holding buffer
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         receive_link_byte_q <= `T1FM_BYTE_RST;
      end else if (byte_done) begin
         receive_link_byte_q <= new_byte; // R11 R13
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags: write one to clear, a new event wins over the clear
   logic one_second_tick_flag_q;
   logic link_byte_full_flag_q;
   logic link_match_flag_q;
   logic link_abort_flag_q;
   logic clr_wr;
   logic match_evt;
   logic abort_evt;

   assign clr_wr = wr_in & (addr_in == `T1FM_OFF_STATUS);
   assign match_evt = byte_done
                      & (new_byte == link_match_byte_a_q || new_byte == link_match_byte_b_q);
   assign abort_evt = link_bit_valid_in & link_bit_in
                      & (ones_run_q == (`T1FM_ABORT_RUN - 4'h1)); // R21

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         one_second_tick_flag_q <= 1'b0;
         link_byte_full_flag_q <= 1'b0;
         link_match_flag_q <= 1'b0;
         link_abort_flag_q <= 1'b0;
      end else begin
         one_second_tick_flag_q <= one_second_in
            | (one_second_tick_flag_q & ~(clr_wr & wdata_in[`T1FM_BIT_ONE_SECOND]));
         link_byte_full_flag_q <= byte_done
            | (link_byte_full_flag_q & ~(clr_wr & wdata_in[`T1FM_BIT_BYTE_FULL])); // R12
         link_match_flag_q <= match_evt
            | (link_match_flag_q & ~(clr_wr & wdata_in[`T1FM_BIT_MATCH])); // R14
         link_abort_flag_q <= abort_evt
            | (link_abort_flag_q & ~(clr_wr & wdata_in[`T1FM_BIT_ABORT])); // R21
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         second_interrupt_n_out <= 1'b1;
      end else begin
         second_interrupt_n_out <= ~((link_byte_full_flag_q & link_byte_full_mask_q)
                                     | (link_match_flag_q & link_match_mask_q)); // R12 R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         case (addr_in)
            `T1FM_OFF_CNT_HIGH: rdata_out <= {sync_loss_count_q[11:8],
                                              path_error_count_q[11:8]}; // R4 R5
            `T1FM_OFF_PATH_LOW: rdata_out <= path_error_count_q[7:0]; // R1
            `T1FM_OFF_SYNC_LOW: rdata_out <= sync_loss_count_q[7:0]; // R5
            `T1FM_OFF_LINK_BYTE: rdata_out <= receive_link_byte_q;
            `T1FM_OFF_MATCH_A: rdata_out <= link_match_byte_a_q;
            `T1FM_OFF_MATCH_B: rdata_out <= link_match_byte_b_q;
            `T1FM_OFF_FRAME_CTRL: rdata_out <= {4'h0, framing_mode_select_q, 2'h0,
                                                zero_destuff_enable_q};
            `T1FM_OFF_RECV_CTRL: rdata_out <= {6'h00, fs_error_count_enable_q,
                                               sync_loss_count_select_q};
            `T1FM_OFF_STATUS: rdata_out <= {2'h0, one_second_tick_flag_q,
                                            link_byte_full_flag_q, 1'b0,
                                            link_match_flag_q, link_abort_flag_q, 1'b0};
            `T1FM_OFF_MASK: rdata_out <= {3'h0, link_byte_full_mask_q, 1'b0,
                                          link_match_mask_q, 2'h0};
            default: rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   a_path_sync_gate: assert property ( // R20
      receive_sync_lost_in && !one_second_in |=> path_live_q == $past(path_live_q))
      else $error("path counter moved during sync loss");

   a_path_esf_crc: assert property ( // R2
      framing_mode_select_q && crc6_error_in && !receive_sync_lost_in && !one_second_in
      && path_live_q != `T1FM_CNT_MAX |=> path_live_q == $past(path_live_q) + 12'h001)
      else $error("crc6 error not counted");

   a_path_d4_fs: assert property ( // R3
      !framing_mode_select_q && !fs_error_count_enable_q && fs_error_in && !ft_error_in
      && !one_second_in |=> path_live_q == $past(path_live_q))
      else $error("fs error counted while disabled");

   a_sync_mos_mode: assert property ( // R6
      sync_loss_count_select_q && multiframe_in && receive_sync_lost_in && !one_second_in
      && sync_live_q != `T1FM_CNT_MAX |=> sync_live_q == $past(sync_live_q) + 12'h001)
      else $error("out-of-sync multiframe not counted");

   a_sync_fbit_gate: assert property ( // R8
      !sync_loss_count_select_q && receive_sync_lost_in && !one_second_in
      |=> sync_live_q == $past(sync_live_q))
      else $error("framing error counted during sync loss");

   a_count_saturate: assert property ( // R19
      path_live_q == `T1FM_CNT_MAX && !one_second_in |=> path_live_q == `T1FM_CNT_MAX)
      else $error("path counter wrapped");

   a_snapshot_load: assert property ( // R18
      one_second_in |=> path_error_count_q == $past(path_live_q)
                        && sync_loss_count_q == $past(sync_live_q))
      else $error("snapshot not loaded on second");

   a_destuff_drop: assert property ( // R15
      drop_zero && link_bit_valid_in |=> bit_cnt_q == $past(bit_cnt_q)
                                         && shift_q == $past(shift_q))
      else $error("stuffed zero entered byte");

   a_six_ones_keep: assert property ( // R16
      link_bit_valid_in && !link_bit_in && ones_run_q > 4'h5
      |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
      else $error("zero after six ones dropped");

   a_byte_full: assert property ( // R12
      byte_done |=> link_byte_full_flag_q && receive_link_byte_q == $past(new_byte)
                    ##1 (second_interrupt_n_out == !link_byte_full_mask_q
                         || link_match_flag_q))
      else $error("full byte not flagged");

   a_match_flag: assert property ( // R14
      byte_done |=> link_match_flag_q || (receive_link_byte_q != link_match_byte_a_q
                                          && receive_link_byte_q != link_match_byte_b_q))
      else $error("match not flagged");

   a_abort_flag: assert property ( // R21
      link_bit_valid_in && link_bit_in && ones_run_q == 4'h7
      |=> link_abort_flag_q && ones_run_q == `T1FM_ABORT_RUN)
      else $error("abort flag not set on eighth one");

   a_lsb_first: assert property ( // R10
      byte_done |=> receive_link_byte_q[7] == $past(link_bit_in))
      else $error("last bit not in msb");

   c_byte_filled: cover property (byte_done);
   c_match_seen: cover property (match_evt);
   c_stuff_dropped: cover property (drop_zero && link_bit_valid_in);
   c_abort_seen: cover property (abort_evt);

endmodule : t1fm_rx_fbit_monitor

// ---- verif/t1fm_host_model.sv ----
// Host microcontroller model driving the monitor's register port.
// Assumes a rising-edge clock shared with the monitor; reads answer one cycle later.
`timescale 1ns/1ps
`include "t1fm_defs.svh"

module t1fm_host_model (
   input wire logic core_clk_in,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire logic [7:0] rdata_in
);
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge core_clk_in);
      wr_out <= 1'b0;
   endtask : write_reg

   // Data is sampled at the edge closing the answer cycle, never later
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge core_clk_in);
      rd_out <= 1'b0;
      @(posedge core_clk_in);
      d = rdata_in;
   endtask : read_reg

   // Called straight after each full byte, well inside one byte period
   task automatic fetch_link_byte(output logic [7:0] d);
      read_reg(`T1FM_OFF_LINK_BYTE, d);
   endtask : fetch_link_byte
endmodule : t1fm_host_model

// ---- verif/test_t1_rx_fbit_monitor.sv ----
// Self-checking bench for the receive F-bit monitor.
// Assumes the host model owns the register port; framer events come from here.
`timescale 1ns/1ps
`include "t1fm_defs.svh"

module test_t1_rx_fbit_monitor;
   typedef struct packed {
      logic [7:0] fctl;
      logic [7:0] rctl;
      logic [4:0] ev;
      logic lost;
      logic [3:0] path;
      logic [3:0] sync;
   } t1fm_cnt_row_t;
   typedef struct packed {
      logic [7:0] fctl;
      logic [7:0] mask;
      logic [3:0] n;
      logic [15:0] bits;
      logic [7:0] val;
      logic [7:0] stat;
      logic irq_n;
   } t1fm_link_row_t;

   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, irq_n;
   logic [4:0] ev = 5'h00;
   logic lost = 1'b0;
   logic sec = 1'b0;
   logic lvalid = 1'b0;
   logic lbit = 1'b0;
   int miscompares = 0;
   int tests_run = 0;

   // Events: {ft, fs, fps, crc6, multiframe}; three pulses per row
   t1fm_cnt_row_t cnt_rows [10] = '{
      '{8'h08, 8'h00, 5'h02, 1'b0, 4'h3, 4'h0},
      '{8'h08, 8'h02, 5'h0e, 1'b0, 4'h3, 4'h3},
      '{8'h08, 8'h00, 5'h10, 1'b0, 4'h0, 4'h0},
      '{8'h00, 8'h00, 5'h10, 1'b0, 4'h3, 4'h3},
      '{8'h00, 8'h00, 5'h08, 1'b0, 4'h0, 4'h0},
      '{8'h00, 8'h02, 5'h08, 1'b0, 4'h3, 4'h0},
      '{8'h00, 8'h00, 5'h06, 1'b0, 4'h0, 4'h0},
      '{8'h00, 8'h00, 5'h10, 1'b1, 4'h0, 4'h0},
      '{8'h08, 8'h01, 5'h03, 1'b1, 4'h0, 4'h3},
      '{8'h00, 8'h01, 5'h11, 1'b0, 4'h3, 4'h0}
   };
   // Bits go out LSB first; row 1 carries one stuffed zero
   t1fm_link_row_t link_rows [4] = '{
      '{8'h08, 8'h00, 4'h8, 16'h005f, 8'h5f, 8'h10, 1'b1},
      '{8'h09, 8'h04, 4'h9, 16'h015f, 8'hbf, 8'h14, 1'b0},
      '{8'h09, 8'h10, 4'h8, 16'h007e, 8'h7e, 8'h14, 1'b0},
      '{8'h09, 8'h04, 4'h8, 16'h00ff, 8'hff, 8'h12, 1'b1}
   };

   t1fm_rx_fbit_monitor t1fm_rx_fbit_monitor_inst (
      .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ft_error_in(ev[4]),
      .fs_error_in(ev[3]), .fps_error_in(ev[2]), .crc6_error_in(ev[1]),
      .multiframe_in(ev[0]), .receive_sync_lost_in(lost), .one_second_in(sec),
      .link_bit_valid_in(lvalid), .link_bit_in(lbit), .second_interrupt_n_out(irq_n)
   );
   t1fm_host_model t1fm_host_model_inst (
      .core_clk_in(core_clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd), .rdata_in(rdata)
   );

   always #5 core_clk_in = ~core_clk_in;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      t1fm_host_model_inst.read_reg(a, d);
      chk(d, exp);
   endtask : rd_chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      t1fm_host_model_inst.write_reg(a, v);
   endtask : wr_reg

   task automatic pulse_ev(input logic [4:0] e, input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         ev <= e;
         @(posedge core_clk_in);
         ev <= 5'h00;
      end
   endtask : pulse_ev

   task automatic tick();
      @(posedge core_clk_in);
      sec <= 1'b1;
      @(posedge core_clk_in);
      sec <= 1'b0;
   endtask : tick

   task automatic send_bit(input logic b);
      @(posedge core_clk_in);
      lvalid <= 1'b1;
      lbit <= b;
      @(posedge core_clk_in);
      lvalid <= 1'b0;
   endtask : send_bit

   task automatic end_of_test();
      $display("Counts: %0d checks, %0d miscompares", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge core_clk_in);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge core_clk_in);
      rst_in <= 1'b0;
      // Reset values across the whole map, unmapped holes included
      for (int a = 8'h25; a <= 8'h33; a++) begin
         rd_chk(a[7:0], 8'h00);
      end
      chk({7'h00, irq_n}, 8'h01);
      wr_reg(8'h28, 8'h5a);
      wr_reg(8'h40, 8'hff);
      rd_chk(8'h28, 8'h00);
      rd_chk(8'h40, 8'h00);
      $display("Test done: reset and map");
      foreach (cnt_rows[i]) begin
         wr_reg(8'h30, cnt_rows[i].fctl);
         wr_reg(8'h31, cnt_rows[i].rctl);
         lost <= cnt_rows[i].lost;
         pulse_ev(cnt_rows[i].ev, 3);
         tick();
         rd_chk(8'h25, 8'h00);
         rd_chk(8'h26, {4'h0, cnt_rows[i].path});
         rd_chk(8'h27, {4'h0, cnt_rows[i].sync});
      end
      lost <= 1'b0;
      $display("Test done: counting modes");
      wr_reg(8'h30, 8'h08);
      wr_reg(8'h31, 8'h00);
      pulse_ev(5'h06, 300);
      pulse_ev(5'h02, 3800);
      tick();
      rd_chk(8'h25, 8'h1f);
      rd_chk(8'h26, 8'hff);
      rd_chk(8'h27, 8'h2c);
      rd_chk(8'h32, 8'h20);
      pulse_ev(5'h02, 2);
      rd_chk(8'h26, 8'hff);
      tick();
      rd_chk(8'h26, 8'h02);
      $display("Test done: saturation and snapshot");
      wr_reg(8'h29, 8'h7e);
      wr_reg(8'h2a, 8'hbf);
      rd_chk(8'h2a, 8'hbf);
      wr_reg(8'h32, 8'hff);
      foreach (link_rows[i]) begin
         wr_reg(8'h30, link_rows[i].fctl);
         wr_reg(8'h33, link_rows[i].mask);
         for (int b = 0; b < int'(link_rows[i].n) - 1; b++) begin
            send_bit(link_rows[i].bits[b]);
         end
         rd_chk(8'h32, 8'h00);
         send_bit(link_rows[i].bits[link_rows[i].n - 4'h1]);
         repeat (3) @(posedge core_clk_in);
         chk({7'h00, irq_n}, {7'h00, link_rows[i].irq_n});
         rd_chk(8'h32, link_rows[i].stat);
         t1fm_host_model_inst.fetch_link_byte(d);
         chk(d, link_rows[i].val);
         wr_reg(8'h32, 8'hff);
         repeat (2) @(posedge core_clk_in);
         chk({7'h00, irq_n}, 8'h01);
      end
      $display("Test done: link extraction");
      // Reset in mid-run must clear the held byte and the snapshot
      rst_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      rst_in <= 1'b0;
      rd_chk(8'h28, 8'h00);
      rd_chk(8'h26, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      $display("Test done: mid-run reset");
      end_of_test();
   end
endmodule : test_t1_rx_fbit_monitor
